/* verilog/gvf_cfg.svh */
// Constants for the guest function dispatch block: offsets, fields, limits.
// Assumes inclusion by bare name from every design file that needs them.
//
// Overview of operation
// - Invalid-opcode fault when functions are disabled or the selector exceeds 63.
// - Otherwise exit the guest when the selected function-control bit is 0.
// - Guest exit reports reason 59 and the invoking instruction length.
// - With no fault and no exit, perform the selected function.
// - Function enable counts as 0 while primary bit 31 is 0.
// - Pointer switching is function number 0.
// - Index of 512 or more exits without any memory read.
// - Valid index fetches 8 bytes at list base plus eight times index.
// - Exit when the fetched pointer fails the entry validity checks.
// - Valid pointer is stored and used for all later translation.
// - Switching changes no architectural register and no flag.
// - Switch exits report nothing beyond reason and instruction length.
// - Successful switch continues at the following instruction.
// - New mappings tagged with pointer bits 51:12, identifiers kept.
// - With identifiers disabled, success invalidates combined mappings of identifier 0.
// - The switch itself never raises a translation exit for the base.
// - Non-extended paging: next linear access retranslates base through new tables.
// - Extended paging: cached directory entries are kept, not reloaded.
// - Extended paging: later accesses translate cached entries through new tables.
// - Function-specific exits save information like the disabled-function exit.
// - Identifier is 0 when disabled; context identifier is 0 when disabled.
`ifndef GVF_CFG_SVH
`define GVF_CFG_SVH

// Register word indexes; byte address is four times the index.
`define GVF_IDX_PRIM 6'h00
`define GVF_IDX_SEC 6'h01
`define GVF_IDX_FUNC_LO 6'h02
`define GVF_IDX_FUNC_HI 6'h03
`define GVF_IDX_LIST_LO 6'h04
`define GVF_IDX_LIST_HI 6'h05
`define GVF_IDX_PTR_LO 6'h06
`define GVF_IDX_PTR_HI 6'h07
`define GVF_IDX_EXIT 6'h08
`define GVF_IDX_STATUS 6'h09

// Control bit positions.
`define GVF_PRIM_ACT_BIT 31
`define GVF_SEC_FUNC_BIT 13
`define GVF_SEC_VIRTUAL_PROCESSOR_ID_BIT 5

// Dispatch limits and codes.
`define GVF_MAX_FUNC 32'h0000_003F
`define GVF_SWITCH_FUNC 32'h0000_0000
`define GVF_LIST_ENTRIES 32'h0000_0200
`define GVF_EXIT_REASON 16'h003B
`define GVF_RST32 32'h0000_0000
`define GVF_RST64 64'h0000_0000_0000_0000

// Pointer tag field and validity fields.
`define GVF_TAG_HI 51
`define GVF_TAG_LO 12
`define GVF_MT_UC 3'h0
`define GVF_MT_WB 3'h6
`define GVF_WALK_LEN 3'h3

`endif

/* verilog/gvf_pkg.sv */
// Types shared by the guest function dispatch design.
// Assumes nothing beyond a SystemVerilog compiler.
package gvf_pkg;

    // Dispatch sequencer states.
    typedef enum logic [1:0] {
        GVF_IDLE = 2'b00,
        GVF_CHECK = 2'b01,
        GVF_FETCH = 2'b10,
        GVF_CONFIRM = 2'b11
    } gvf_state_e;

endpackage : gvf_pkg

/* verilog/gvf_ptr_check.sv */
// Combinational validity check on a candidate page table pointer.
// Assumes the candidate is stable while the caller samples the result.
`timescale 1ns/10ps
`include "gvf_cfg.svh"

module gvf_ptr_check (
    input wire logic [63:0] cand,
    output logic ok
);

    // Same checks as at guest entry: memory type, walk length, zero reserved bits.
    always_comb begin
        ok = ((cand[2:0] == `GVF_MT_UC) || (cand[2:0] == `GVF_MT_WB))
            && (cand[5:3] == `GVF_WALK_LEN)
            && (cand[11:7] == 5'h00)
            && (cand[63:`GVF_TAG_HI + 1] == 12'h000);
    end

endmodule : gvf_ptr_check

/* verilog/gvf_dispatch.sv */
// Guest function dispatch: decides fault, guest exit or function 0 (pointer switch).
// Assumes guest request, memory answer and paging state come from logic on sys_clk;
// hypervisor controls arrive over an Avalon-MM slave with waitrequest.
`timescale 1ns/10ps
`include "gvf_cfg.svh"

module gvf_dispatch (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ce,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Guest request.
    input wire logic function_invoke_instr,
    input wire logic [31:0] function_selector_reg,
    input wire logic [31:0] entry_index_reg,
    input wire logic [3:0] instr_len,
    input wire logic [15:0] virtual_processor_id,
    input wire logic [11:0] process_context_id,
    input wire logic context_id_enable_bit,
    input wire logic paging_enable_bit,
    input wire logic addr_extension_bit,
    input wire logic long_mode_active_bit,
    input wire logic linear_access,
    input wire logic dir_entry_reload,
    // Pointer list fetch.
    output logic mem_read,
    output logic [63:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [63:0] mem_rdata,
    // Outcomes and side effects.
    output logic invalid_opcode_fault,
    output logic guest_exit,
    output logic [15:0] exit_reason,
    output logic [3:0] exit_instr_len,
    output logic resume_next,
    output logic busy,
    output logic [63:0] page_table_pointer,
    output logic [39:0] page_table_root_tag,
    output logic [15:0] cur_virtual_processor_id,
    output logic [11:0] cur_process_context_id,
    output logic inv_combined_vpid0,
    output logic base_xlate_new,
    output logic dir_entry_xlate_new
);

    // ************************************************************
    // Functions
    // ************************************************************

    // Merge write data into a register under Avalon byte enables.
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_be

    // ************************************************************
    // Declarations
    // ************************************************************

    logic [31:0] prim_ctrl_r;
    logic [31:0] sec_ctrl_r;
    logic [63:0] func_ctrl_r;
    logic [63:0] list_base_r;
    logic [63:0] ptr_r;
    logic [63:0] ptr_nxt;
    logic [31:0] readdata_r;
    logic [31:0] rd_nxt;
    logic wait_r;
    gvf_pkg::gvf_state_e state_r;
    logic [31:0] sel_r;
    logic [31:0] idx_r;
    logic [3:0] len_r;
    logic [63:0] cand_r;
    logic cand_ok;
    logic ud_r;
    logic exit_r;
    logic [15:0] reason_r;
    logic [3:0] exit_len_r;
    logic resume_r;
    logic mem_read_r;
    logic [63:0] mem_addr_r;
    logic [39:0] tag_r;
    logic [15:0] virtual_processor_id_r;
    logic [11:0] process_context_id_r;
    logic inv_r;
    logic base_new_r;
    logic pde_new_r;
    logic func_en;
    logic virtual_processor_id_en;
    logic bus_wr;
    logic switch_ok;

    // Secondary controls only count while the primary activation bit is set.
    assign func_en = prim_ctrl_r[`GVF_PRIM_ACT_BIT] & sec_ctrl_r[`GVF_SEC_FUNC_BIT];
    assign virtual_processor_id_en = prim_ctrl_r[`GVF_PRIM_ACT_BIT] & sec_ctrl_r[`GVF_SEC_VIRTUAL_PROCESSOR_ID_BIT];
    assign bus_wr = avs_write & ~wait_r & ce;
    assign switch_ok = ce & (state_r == gvf_pkg::GVF_CONFIRM) & cand_ok;

    gvf_ptr_check u_check (
        .cand(cand_r),
        .ok(cand_ok)
    );

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************

    // Every access takes one wait cycle, then completes; data is registered.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_r <= 1'b1;
        end else if (ce) begin
            wait_r <= ~((avs_read | avs_write) & wait_r);
        end
    end

    // Read mux; unmapped words read as zero.
    always_comb begin
        rd_nxt = `GVF_RST32;
        case (avs_address[7:2])
            `GVF_IDX_PRIM: rd_nxt = prim_ctrl_r;
            `GVF_IDX_SEC: rd_nxt = sec_ctrl_r;
            `GVF_IDX_FUNC_LO: rd_nxt = func_ctrl_r[31:0];
            `GVF_IDX_FUNC_HI: rd_nxt = func_ctrl_r[63:32];
            `GVF_IDX_LIST_LO: rd_nxt = list_base_r[31:0];
            `GVF_IDX_LIST_HI: rd_nxt = list_base_r[63:32];
            `GVF_IDX_PTR_LO: rd_nxt = ptr_r[31:0];
            `GVF_IDX_PTR_HI: rd_nxt = ptr_r[63:32];
            `GVF_IDX_EXIT: rd_nxt = {12'h000, exit_len_r, reason_r};
            `GVF_IDX_STATUS: rd_nxt = {26'h000_0000, pde_new_r, base_new_r,
                                       (state_r != gvf_pkg::GVF_IDLE), 1'b0, state_r};
            default: rd_nxt = `GVF_RST32;
        endcase
    end

    // Read data is captured as waitrequest drops, so it stands at the taking edge.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            readdata_r <= `GVF_RST32;
        end else if (ce && avs_read && wait_r) begin
            readdata_r <= rd_nxt;
        end
    end

    // Hypervisor controls; the guest cannot reach these.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prim_ctrl_r <= `GVF_RST32;
            sec_ctrl_r <= `GVF_RST32;
            func_ctrl_r <= `GVF_RST64;
            list_base_r <= `GVF_RST64;
        end else if (bus_wr) begin
            case (avs_address[7:2])
                `GVF_IDX_PRIM: prim_ctrl_r <= merge_be(prim_ctrl_r, avs_writedata, avs_byteenable);
                `GVF_IDX_SEC: sec_ctrl_r <= merge_be(sec_ctrl_r, avs_writedata, avs_byteenable);
                `GVF_IDX_FUNC_LO: func_ctrl_r[31:0] <= merge_be(func_ctrl_r[31:0],
                                                           avs_writedata, avs_byteenable);
                `GVF_IDX_FUNC_HI: func_ctrl_r[63:32] <= merge_be(func_ctrl_r[63:32],
                                                            avs_writedata, avs_byteenable);
                `GVF_IDX_LIST_LO: list_base_r[31:0] <= merge_be(list_base_r[31:0],
                                                           avs_writedata, avs_byteenable);
                `GVF_IDX_LIST_HI: list_base_r[63:32] <= merge_be(list_base_r[63:32],
                                                            avs_writedata, avs_byteenable);
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Dispatch sequencer
    // ************************************************************

    // One outcome per accepted request; requests while busy are ignored.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= gvf_pkg::GVF_IDLE;
            sel_r <= `GVF_RST32;
            idx_r <= `GVF_RST32;
            len_r <= 4'h0;
            cand_r <= `GVF_RST64;
            ud_r <= 1'b0;
            exit_r <= 1'b0;
            reason_r <= 16'h0000;
            exit_len_r <= 4'h0;
            resume_r <= 1'b0;
            mem_read_r <= 1'b0;
            mem_addr_r <= `GVF_RST64;
        end else if (ce) begin
            ud_r <= 1'b0;
            exit_r <= 1'b0;
            resume_r <= 1'b0;
            unique case (state_r)
                gvf_pkg::GVF_IDLE: begin
                    if (function_invoke_instr) begin
                        sel_r <= function_selector_reg;
                        idx_r <= entry_index_reg;
                        len_r <= instr_len;
                        state_r <= gvf_pkg::GVF_CHECK;
                    end
                end
                gvf_pkg::GVF_CHECK: begin
                    // Checks in fixed order; the first that fails decides.
                    if (!func_en || (sel_r > `GVF_MAX_FUNC)) begin
                        ud_r <= 1'b1;
                        state_r <= gvf_pkg::GVF_IDLE;
                    end else if (!func_ctrl_r[sel_r[5:0]] || (sel_r != `GVF_SWITCH_FUNC)) begin
                        // Only function 0 exists here; any other selection exits.
                        exit_r <= 1'b1;
                        reason_r <= `GVF_EXIT_REASON;
                        exit_len_r <= len_r;
                        state_r <= gvf_pkg::GVF_IDLE;
                    end else if (idx_r >= `GVF_LIST_ENTRIES) begin
                        exit_r <= 1'b1;
                        reason_r <= `GVF_EXIT_REASON;
                        exit_len_r <= len_r;
                        state_r <= gvf_pkg::GVF_IDLE;
                    end else begin
                        // The list is 4-KByte aligned, so concatenation forms the address.
                        mem_read_r <= 1'b1;
                        mem_addr_r <= {list_base_r[63:12], idx_r[8:0], 3'h0};
                        state_r <= gvf_pkg::GVF_FETCH;
                    end
                end
                gvf_pkg::GVF_FETCH: begin
                    if (mem_ack) begin
                        mem_read_r <= 1'b0;
                        cand_r <= mem_rdata;
                        state_r <= gvf_pkg::GVF_CONFIRM;
                    end
                end
                gvf_pkg::GVF_CONFIRM: begin
                    if (!cand_ok) begin
                        // Only reason and length are recorded; no extra exit detail.
                        exit_r <= 1'b1;
                        reason_r <= `GVF_EXIT_REASON;
                        exit_len_r <= len_r;
                    end else begin
                        resume_r <= 1'b1;
                    end
                    state_r <= gvf_pkg::GVF_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Pointer and mapping tags
    // ************************************************************

    // Switch wins over a bus write in the same cycle; nothing else is touched.
    always_comb begin
        ptr_nxt = ptr_r;
        if (switch_ok) begin
            ptr_nxt = cand_r;
        end else if (bus_wr && (avs_address[7:2] == `GVF_IDX_PTR_LO)) begin
            ptr_nxt[31:0] = merge_be(ptr_r[31:0], avs_writedata, avs_byteenable);
        end else if (bus_wr && (avs_address[7:2] == `GVF_IDX_PTR_HI)) begin
            ptr_nxt[63:32] = merge_be(ptr_r[63:32], avs_writedata, avs_byteenable);
        end
    end

    // The tag always follows the live pointer.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ptr_r <= `GVF_RST64;
            tag_r <= 40'h00_0000_0000;
        end else if (ce) begin
            ptr_r <= ptr_nxt;
            tag_r <= ptr_nxt[`GVF_TAG_HI:`GVF_TAG_LO];
        end
    end

    // Current identifiers pass through unchanged by a switch.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            virtual_processor_id_r <= 16'h0000;
            process_context_id_r <= 12'h000;
            inv_r <= 1'b0;
        end else if (ce) begin
            virtual_processor_id_r <= virtual_processor_id_en ? virtual_processor_id : 16'h0000;
            process_context_id_r <= context_id_enable_bit ? process_context_id : 12'h000;
            inv_r <= switch_ok & ~virtual_processor_id_en;
        end
    end

    // ************************************************************
    // Retranslation flags
    // ************************************************************

    // The switch raises no translation fault itself; it only marks which cached
    // address must go through the new tables on the next access.
    // A set in the same cycle as a clear wins.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            base_new_r <= 1'b0;
            pde_new_r <= 1'b0;
        end else if (ce) begin
            if (switch_ok && paging_enable_bit && (!addr_extension_bit || long_mode_active_bit)) begin
                base_new_r <= 1'b1;
            end else if (linear_access) begin
                base_new_r <= 1'b0;
            end
            // Cached directory entries are not reloaded; they are retranslated later.
            if (switch_ok && paging_enable_bit && addr_extension_bit && !long_mode_active_bit) begin
                pde_new_r <= 1'b1;
            end else if (dir_entry_reload) begin
                pde_new_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = wait_r;
    assign mem_read = mem_read_r;
    assign mem_addr = mem_addr_r;
    assign invalid_opcode_fault = ud_r;
    assign guest_exit = exit_r;
    assign exit_reason = reason_r;
    assign exit_instr_len = exit_len_r;
    assign resume_next = resume_r;
    assign busy = mem_read_r;
    assign page_table_pointer = ptr_r;
    assign page_table_root_tag = tag_r;
    assign cur_virtual_processor_id = virtual_processor_id_r;
    assign cur_process_context_id = process_context_id_r;
    assign inv_combined_vpid0 = inv_r;
    assign base_xlate_new = base_new_r;
    assign dir_entry_xlate_new = pde_new_r;

    // ************************************************************
    // Assertions
    // ************************************************************

    a_ud_bad_select: assert property (@(posedge sys_clk) disable iff (srst)
        ce && state_r == gvf_pkg::GVF_CHECK && sel_r > `GVF_MAX_FUNC |=> ud_r && !exit_r)
        else $error("selector above limit did not fault");

    a_ud_inactive_prim: assert property (@(posedge sys_clk) disable iff (srst)
        ce && state_r == gvf_pkg::GVF_CHECK && !prim_ctrl_r[`GVF_PRIM_ACT_BIT] |=> ud_r)
        else $error("inactive primary control did not fault");

    a_exit_disabled_fn: assert property (@(posedge sys_clk) disable iff (srst)
        ce && state_r == gvf_pkg::GVF_CHECK && func_en && sel_r <= `GVF_MAX_FUNC
        && !func_ctrl_r[sel_r[5:0]] |=> exit_r && reason_r == `GVF_EXIT_REASON)
        else $error("disabled function did not exit");

    a_exit_len_kept: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(exit_r) |-> exit_len_r == len_r && reason_r == `GVF_EXIT_REASON)
        else $error("exit information wrong");

    a_index_no_fetch: assert property (@(posedge sys_clk) disable iff (srst)
        ce && state_r == gvf_pkg::GVF_CHECK && func_en && sel_r == `GVF_SWITCH_FUNC
        && func_ctrl_r[0] && idx_r >= `GVF_LIST_ENTRIES |=> exit_r && !mem_read_r)
        else $error("out of range index fetched memory");

    a_fetch_addr: assert property (@(posedge sys_clk) disable iff (srst)
        mem_read_r |-> mem_addr_r == {list_base_r[63:12], 12'h000}
        + {52'h0_0000_0000_0000, idx_r[8:0], 3'h0})
        else $error("fetch address wrong");

    a_bad_cand_keep: assert property (@(posedge sys_clk) disable iff (srst)
        ce && state_r == gvf_pkg::GVF_CONFIRM && !cand_ok && !bus_wr
        |=> exit_r && !resume_r && $stable(ptr_r))
        else $error("invalid pointer was not refused");

    a_switch_load: assert property (@(posedge sys_clk) disable iff (srst)
        switch_ok |=> ptr_r == $past(cand_r) && resume_r ##1 !resume_r || !ce)
        else $error("valid pointer not loaded");

    a_tag_follow: assert property (@(posedge sys_clk) disable iff (srst)
        resume_r |-> tag_r == ptr_r[`GVF_TAG_HI:`GVF_TAG_LO] && inv_r == !virtual_processor_id_en)
        else $error("tag or invalidation wrong after switch");

    a_one_outcome: assert property (@(posedge sys_clk) disable iff (srst)
        $onehot0({ud_r, exit_r, resume_r}))
        else $error("more than one outcome");

endmodule : gvf_dispatch

/* dv/gvf_list_mem.sv */
// List memory model that answers pointer fetches from the dispatch block.
// Assumes the bench sets answer and delay before each guest request.
`timescale 1ns/10ps
module gvf_list_mem (
    input wire logic sys_clk,
    input wire logic mem_read,
    input wire logic [63:0] answer,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [63:0] mem_rdata
);
    logic [3:0] wait_r = 4'h0;

    // Data lines flip every cycle outside an answer, so no stale word looks valid.
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_read === 1'b1 && mem_ack !== 1'b1) begin
            if (wait_r == delay) begin
                mem_ack <= 1'b1;
                mem_rdata <= answer;
                wait_r <= 4'h0;
            end else begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
    initial mem_rdata = 64'h0000_0000_0000_0000;
endmodule : gvf_list_mem

/* dv/tb_top.sv */
// Self-checking bench for the guest function dispatch block.
// Assumes the design files and the list memory model are compiled first.
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, seed, r;
    logic avs_waitrequest, mem_read, mem_ack, invalid_opcode_fault, guest_exit;
    logic resume_next, inv_combined_vpid0, function_invoke_instr = 1'b0;
    logic busy, base_xlate_new, dir_entry_xlate_new, clr = 1'b0;
    logic [31:0] function_selector_reg = 32'h0000_0000, entry_index_reg = 32'h0000_0000;
    logic [3:0] instr_len = 4'h0, exit_instr_len, delay = 4'h0;
    logic [15:0] virtual_processor_id = 16'h0000, exit_reason, cur_virtual_processor_id;
    logic [11:0] process_context_id = 12'h000, cur_process_context_id;
    logic context_id_enable_bit = 1'b0, addr_extension_bit = 1'b0, long_mode_active_bit = 1'b0;
    logic [63:0] mem_addr, mem_rdata, page_table_pointer, answer = 64'h0000_0000_0000_0000;
    logic [39:0] page_table_root_tag;
    int mismatches = 0, checked = 0;

    // Free-running 10 MHz clock.
    always #50 sys_clk = ~sys_clk;

    gvf_dispatch DUT (.sys_clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .function_invoke_instr, .function_selector_reg, .entry_index_reg, .instr_len,
        .virtual_processor_id, .process_context_id, .context_id_enable_bit,
        .paging_enable_bit(1'b1), .addr_extension_bit, .long_mode_active_bit,
        .linear_access(clr), .dir_entry_reload(clr), .mem_read, .mem_addr, .mem_ack,
        .mem_rdata, .invalid_opcode_fault, .guest_exit, .exit_reason, .exit_instr_len,
        .resume_next, .busy, .page_table_pointer, .page_table_root_tag, .cur_virtual_processor_id,
        .cur_process_context_id, .inv_combined_vpid0, .base_xlate_new, .dir_entry_xlate_new);
    gvf_list_mem MEM (.sys_clk, .mem_read, .answer, .delay, .mem_ack, .mem_rdata);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic final_report;
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One Avalon access; the request is held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                mismatches++;
                final_report();
            end
            @(posedge sys_clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Expected outcome: 1 fault, 2 guest exit, 3 switch done; checks go in this order.
    function automatic logic [1:0] want_of(input logic en, input logic [63:0] fm,
        input logic [31:0] s, input logic [31:0] x, input logic good);
        if (!en || s > 32'd63) return 2'd1;
        if (!fm[s[5:0]] || s != 32'd0 || x >= 32'd512 || !good) return 2'd2;
        return 2'd3;
    endfunction : want_of

    // Configure the controls, issue one guest request and judge its outcome.
    task automatic run(input logic pon, input logic fen, input logic ven, input logic [63:0] fm,
                       input logic [31:0] s, input logic [31:0] x, input logic good);
        logic [31:0] q;
        logic [63:0] base, val;
        logic [1:0] got, want;
        logic rd;
        int n;
        base = {$random(seed), $random(seed)};
        val = {12'h000, 8'($random(seed)), $random(seed), 12'h01E};
        val[7] = ~good;
        bus(1'b1, 8'h00, {pon, 31'h0}, q);
        bus(1'b1, 8'h04, {18'h0, fen, 7'h0, ven, 5'h0}, q);
        bus(1'b1, 8'h08, fm[31:0], q);
        bus(1'b1, 8'h0C, fm[63:32], q);
        bus(1'b1, 8'h10, base[31:0], q);
        bus(1'b1, 8'h14, base[63:32], q);
        r = $random(seed);
        answer <= val;
        delay <= r[3:0];
        function_invoke_instr <= 1'b1;
        clr <= 1'b1;
        function_selector_reg <= s;
        entry_index_reg <= x;
        {instr_len, virtual_processor_id, process_context_id} <= {r[4:1], r[31:16], r[11:0]};
        {context_id_enable_bit, addr_extension_bit, long_mode_active_bit} <= r[14:12];
        @(posedge sys_clk);
        function_invoke_instr <= 1'b0;
        clr <= 1'b0;
        {got, rd, n} = 0;
        while (got == 2'd0 && n < 60) begin
            @(posedge sys_clk);
            n++;
            if (mem_read === 1'b1) begin
                rd = 1'b1;
                chk("mem_addr", {base[63:12], x[8:0], 3'h0}, mem_addr);
                chk("busy", 1'b1, busy);
            end
            got = (invalid_opcode_fault === 1'b1) ? 2'd1 : (guest_exit === 1'b1) ? 2'd2 :
                  (resume_next === 1'b1) ? 2'd3 : 2'd0;
        end
        want = want_of(pon & fen, fm, s, x, good);
        chk("outcome", want, got);
        chk("list_read", pon & fen & fm[0] & (s == 0) & (x < 512), rd);
        chk("base_new", want == 2'd3 && (!r[13] || r[12]), base_xlate_new);
        chk("entry_new", want == 2'd3 && r[13] && !r[12], dir_entry_xlate_new);
        if (n >= 60) final_report();
        if (want == 2'd2) begin
            chk("exit_reason", 16'h003B, exit_reason);
            chk("exit_len", r[4:1], exit_instr_len);
            bus(1'b0, 8'h20, 32'h0000_0000, q);
            chk("exit_info", {12'h000, r[4:1], 16'h003B}, q);
        end
        if (want == 2'd3) begin
            chk("pointer", val, page_table_pointer);
            chk("root_tag", val[51:12], page_table_root_tag);
            chk("flush", !ven, inv_combined_vpid0);
            chk("virtual_processor_id", ven ? r[31:16] : 16'h0000, cur_virtual_processor_id);
            chk("process_context_id", r[14] ? r[11:0] : 12'h000, cur_process_context_id);
            bus(1'b0, 8'h18, 32'h0000_0000, q);
            chk("pointer_lo", val[31:0], q);
        end
    endtask : run

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] q;
        seed = 32'h2bd5_a7af;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        chk("rest_wait", 1'b1, avs_waitrequest);
        bus(1'b0, 8'h80, 32'h0000_0000, q);
        chk("unmapped", 32'h0000_0000, q);
        run(1'b1, 1'b1, 1'b0, 64'h1, 32'd0, 32'd512, 1'b1);
        run(1'b1, 1'b1, 1'b0, 64'h1, 32'd0, 32'd511, 1'b1);
        run(1'b1, 1'b1, 1'b1, 64'h1, 32'd0, 32'd3, 1'b0);
        run(1'b1, 1'b1, 1'b1, 64'h2, 32'd0, 32'd0, 1'b1);
        run(1'b1, 1'b1, 1'b1, '1, 32'd64, 32'd0, 1'b1);
        run(1'b1, 1'b1, 1'b1, '1, 32'd63, 32'd0, 1'b1);
        run(1'b0, 1'b1, 1'b1, '1, 32'd0, 32'd0, 1'b1);
        run(1'b1, 1'b0, 1'b1, '1, 32'd0, 32'd0, 1'b1);
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            run(r[0] | r[1], r[2] | r[3], r[4], {$random(seed), $random(seed) | 32'h1},
                r[5] ? 32'(r[12:6]) : 32'd0, 32'(r[22:13]), r[23] | r[24]);
        end
        final_report();
    end
endmodule : tb_top
